// ---- bench/light_sensor_control_interrupt_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module light_sensor_control_interrupt_tb_top
  import lsci_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  lsci_req_type req = '0;
  logic [7:0]   rdata;
  logic         osc, integ, irs, int_n;
  logic [1:0]   scl;
  logic [15:0]  amb_v = '0, ir_v = '0, amb, ir;
  int           mismatches = 0, checks_done = 0, cyc = 0;
  logic [23:0]  rows [8] = '{24'h01ff0f, 24'h040303, 24'h050000, 24'h060c0c,
                            24'h070000, 24'h02aa00, 24'h095500, 24'h001b03};
  logic [7:0]   rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  lsci_core #(.INTEG_CYCLES_16B(32)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .osc_clk_i(osc), .ambient_data_i(amb),
    .infrared_data_i(ir), .integrating_o(integ), .ir_sel_o(irs), .scale_sel_o(scl),
    .int_n_o(int_n));
  lsci_front_model i_front (.run_i(integ), .amb_val_i(amb_v), .ir_val_i(ir_v), .osc_o(osc),
    .amb_o(amb), .ir_o(ir));
  initial forever #20 clk_i = !clk_i;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i) req = '{1'b1, 1'b0, a, d};
    @(negedge clk_i) req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i) req.addr = a;
    @(negedge clk_i) chk(rdata, e);
    req.rd_done = 1'b1;
    @(negedge clk_i) req.rd_done = 1'b0;
  endtask
  task automatic conv_wait();
    for (int i = 0; i < 400 && integ; i++) @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk(8'(scl), 8'h03);
    amb_v = 16'h1237;
    wr(8'h00, 8'h20);
    conv_wait();
    rd(8'h02, 8'h07);
    rd(8'h03, 8'h00);
    chk(8'(int_n), 8'h01);
    ir_v = 16'h00fc;
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h40);
    chk(8'(irs), 8'h01);
    conv_wait();
    chk(8'(int_n), 8'h00);
    rd(8'h00, 8'h44);
    chk(8'(int_n), 8'h01);
    amb_v = 16'h0003;
    wr(8'h00, 8'ha1);
    repeat (440) @(negedge clk_i);
    chk(8'(int_n), 8'h01);
    repeat (140) @(negedge clk_i);
    chk(8'(int_n), 8'h00);
    amb_v = 16'h0007;
    repeat (300) @(negedge clk_i);
    chk(8'(int_n), 8'h00);
    rd(8'h00, 8'ha5);
    chk(8'(int_n), 8'h01);
    wr(8'h00, 8'h00);
    chk(8'(integ), 8'h00);
    wr(8'h00, 8'hc0);
    chk(8'(integ), 8'h01);
    chk(8'(irs), 8'h01);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(8'(integ), 8'h00);
    foreach (rst_v[i]) rd(8'(i), rst_v[i]);
    summarize();
  end
endmodule
`default_nettype wire

// ---- bench/lsci_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsci_core_sva
  import lsci_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire lsci_req_type reg_req_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic         integrating_o,
  input wire logic         ir_sel_o,
  input wire logic [1:0]   scale_sel_o,
  input wire logic         int_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic w0, w1, r0;
  assign w0 = reg_req_i.wr && reg_req_i.addr == 8'h00;
  assign w1 = reg_req_i.wr && reg_req_i.addr == 8'h01;
  assign r0 = reg_req_i.rd_done && reg_req_i.addr == 8'h00;
  AST_RST_IDLE: assert property ($fell(sys_rst_i) |-> int_n_o && !integrating_o)
    else $error("outputs not idle after reset");
  AST_INT_HOLD: assert property (!int_n_o && !r0 |=> !int_n_o)
    else $error("interrupt released without read");
  AST_INT_CLEAR: assert property (r0 && !integrating_o |=> int_n_o)
    else $error("interrupt not cleared by read");
  AST_FLAG_READ: assert property (reg_req_i.addr == 8'h00 |=> reg_rdata_o[2] == !$past(int_n_o))
    else $error("status flag differs from pin");
  AST_MODE_OFF: assert property (w0 && !(reg_req_i.wdata[7:5] inside {3'h1, 3'h2, 3'h5, 3'h6})
    |=> !integrating_o) else $error("converting in idle mode");
  AST_MODE_RUN: assert property (w0 && reg_req_i.wdata[7] && ^reg_req_i.wdata[6:5]
    |=> integrating_o && ir_sel_o == $past(reg_req_i.wdata[6])) else $error("run mode wrong");
  AST_SCALE: assert property (w1 |=> scale_sel_o == $past(reg_req_i.wdata[1:0]))
    else $error("range field not applied");
  AST_SCALE_HOLD: assert property (!w1 |=> $stable(scale_sel_o))
    else $error("range field changed");
  cover property (!int_n_o);
  cover property (r0 && !int_n_o);
  cover property ($rose(integrating_o));
endmodule
bind lsci_core lsci_core_sva i_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .integrating_o(integrating_o), .ir_sel_o(ir_sel_o),
  .scale_sel_o(scale_sel_o), .int_n_o(int_n_o));
`default_nettype wire

// ---- bench/lsci_front_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsci_front_model (
  input  wire logic        run_i,
  input  wire logic [15:0] amb_val_i,
  input  wire logic [15:0] ir_val_i,
  output logic             osc_o,
  output logic [15:0]      amb_o,
  output logic [15:0]      ir_o
);
  // Oscillator toggles only while a conversion runs, out of phase with the system clock.
  initial begin
    osc_o = 1'b0;
    #7;
    forever begin
      #160;
      osc_o = run_i ? !osc_o : 1'b0;
    end
  end
  assign amb_o = amb_val_i;
  assign ir_o  = ir_val_i;
endmodule
`default_nettype wire

// ---- include/lsci_pkg.sv ----
// Functional notes
// - First control register resets to zero.
// - Mode and persistence fields act independently.
// - Persistence needs 1/4/8/16 consecutive outside results.
// - Active-low interrupt holds until host clears.
// - Bit 2 reads the triggered interrupt flag.
// - Trigger drives pin low, sets flag together.
// - Completed read of address zero clears both.
// - Mode field selects power-down, single, continuous.
// - Powered down after reset until mode written.
// - Second control register: range, resolution, reset zero.
// - Range selects ambient full scale, infrared fixed.
// - Resolution sets oscillator cycles per integration.
// - Result low byte 0x02, high 0x03.
// - Valid result bits start at bit zero.
// - Result updates each conversion, resets to zero.
// - Result at or below lower limit is outside.
// - Lower limit bytes reset to zero.
// - Result at or above upper limit is outside.
// - Upper limit bytes reset to all ones.
`default_nettype none
package lsci_pkg;

  localparam logic [7:0] LSCI_ADDR_MODE   = 8'h00;
  localparam logic [7:0] LSCI_ADDR_RANGE  = 8'h01;
  localparam logic [7:0] LSCI_ADDR_RES_LO = 8'h02;
  localparam logic [7:0] LSCI_ADDR_RES_HI = 8'h03;
  localparam logic [7:0] LSCI_ADDR_LLO    = 8'h04;
  localparam logic [7:0] LSCI_ADDR_LHI    = 8'h05;
  localparam logic [7:0] LSCI_ADDR_ULO    = 8'h06;
  localparam logic [7:0] LSCI_ADDR_UHI    = 8'h07;

  localparam int LSCI_MODE_LSB    = 5;
  localparam int LSCI_FLAG_BIT    = 2;
  localparam int LSCI_PERSIST_LSB = 0;
  localparam int LSCI_SCALE_LSB   = 0;
  localparam int LSCI_RESOL_LSB   = 2;

  localparam logic [2:0] LSCI_MODE_OFF     = 3'h0;
  localparam logic [2:0] LSCI_MODE_AMB_ONE = 3'h1;
  localparam logic [2:0] LSCI_MODE_IR_ONE  = 3'h2;
  localparam logic [2:0] LSCI_MODE_AMB_RUN = 3'h5;
  localparam logic [2:0] LSCI_MODE_IR_RUN  = 3'h6;

  localparam int LSCI_CYC_16B = 65536;
  localparam int LSCI_CYC_12B = 4096;
  localparam int LSCI_CYC_8B  = 256;
  localparam int LSCI_CYC_4B  = 16;

  localparam logic [7:0]  LSCI_MODE_RST   = 8'h00;
  localparam logic [7:0]  LSCI_RANGE_RST  = 8'h00;
  localparam logic [15:0] LSCI_RESULT_RST = 16'h0000;
  localparam logic [15:0] LSCI_LOWER_RST  = 16'h0000;
  localparam logic [15:0] LSCI_UPPER_RST  = 16'hffff;

  typedef enum logic [2:0] {
    LSCI_OFF  = 3'b001,
    LSCI_RUN  = 3'b010,
    LSCI_HOLD = 3'b100
  } lsci_fsm_type;

  typedef struct packed {
    logic       wr;
    logic       rd_done;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsci_req_type;

  typedef struct packed {
    lsci_fsm_type fsm;
    logic [2:0]   osc_sync;
    logic         osc_lvl;
    logic [15:0]  osc_cnt;
    logic [2:0]   mode;
    logic [1:0]   persist;
    logic         flag;
    logic [1:0]   scale;
    logic [1:0]   resol;
    logic [15:0]  result;
    logic [15:0]  lower;
    logic [15:0]  upper;
    logic [4:0]   pcnt;
    logic [7:0]   rdata;
  } lsci_state_type;

  localparam lsci_state_type LSCI_STATE_RST = '{
    fsm:      LSCI_OFF,
    osc_sync: 3'h0,
    osc_lvl:  1'b0,
    osc_cnt:  16'h0000,
    mode:     LSCI_MODE_RST[7:5],
    persist:  LSCI_MODE_RST[1:0],
    flag:     LSCI_MODE_RST[2],
    scale:    LSCI_RANGE_RST[1:0],
    resol:    LSCI_RANGE_RST[3:2],
    result:   LSCI_RESULT_RST,
    lower:    LSCI_LOWER_RST,
    upper:    LSCI_UPPER_RST,
    pcnt:     5'h00,
    rdata:    8'h00
  };

  function automatic logic [4:0] lsci_persist_n(input logic [1:0] code);
    logic [4:0] n;
    n = 5'h01;
    unique case (code)
      2'h0: n = 5'h01;
      2'h1: n = 5'h04;
      2'h2: n = 5'h08;
      2'h3: n = 5'h10;
    endcase
    return n;
  endfunction

  function automatic logic [15:0] lsci_res_mask(input logic [1:0] code);
    logic [15:0] m;
    m = 16'hffff;
    unique case (code)
      2'h0: m = 16'hffff;
      2'h1: m = 16'h0fff;
      2'h2: m = 16'h00ff;
      2'h3: m = 16'h000f;
    endcase
    return m;
  endfunction

  function automatic logic lsci_mode_valid(input logic [2:0] mode);
    return (mode == LSCI_MODE_AMB_ONE) || (mode == LSCI_MODE_IR_ONE) ||
           (mode == LSCI_MODE_AMB_RUN) || (mode == LSCI_MODE_IR_RUN);
  endfunction

endpackage
`default_nettype wire

// ---- rtl/lsci_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsci_core
  import lsci_pkg::*;
#(
  parameter int INTEG_CYCLES_16B = LSCI_CYC_16B
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire lsci_req_type reg_req_i,
  output logic [7:0]        reg_rdata_o,
  input  wire logic         osc_clk_i,
  input  wire logic [15:0]  ambient_data_i,
  input  wire logic [15:0]  infrared_data_i,
  output logic              integrating_o,
  output logic              ir_sel_o,
  output logic [1:0]        scale_sel_o,
  output logic              int_n_o
);

  // Refuses integration lengths that the 16-bit cycle counter cannot hold.
  if (INTEG_CYCLES_16B < 2 || INTEG_CYCLES_16B > LSCI_CYC_16B) begin : g_integ_check
    $error("INTEG_CYCLES_16B out of range");
  end

  lsci_state_type state_reg;
  lsci_state_type state_next;

  function automatic logic [15:0] integ_last(input logic [1:0] code);
    logic [15:0] t;
    t = 16'h0000;
    unique case (code)
      2'h0: t = 16'(INTEG_CYCLES_16B - 1);
      2'h1: t = 16'(LSCI_CYC_12B - 1);
      2'h2: t = 16'(LSCI_CYC_8B - 1);
      2'h3: t = 16'(LSCI_CYC_4B - 1);
    endcase
    return t;
  endfunction

  always_comb begin
    logic        osc_rise;
    logic [15:0] sample;
    logic        outside;
    logic [4:0]  pinc;
    osc_rise = 1'b0;
    sample   = 16'h0000;
    outside  = 1'b0;
    pinc     = 5'h00;
    state_next = state_reg;

    // Oscillator edge is accepted once the second and third stages agree.
    state_next.osc_sync = {state_reg.osc_sync[1:0], osc_clk_i};
    if (state_reg.osc_sync[1] == state_reg.osc_sync[2]) begin
      state_next.osc_lvl = state_reg.osc_sync[2];
      osc_rise = state_reg.osc_sync[2] && !state_reg.osc_lvl;
    end

    if (reg_req_i.rd_done && reg_req_i.addr == LSCI_ADDR_MODE) begin
      state_next.flag = 1'b0;
    end

    if (state_reg.fsm == LSCI_RUN && osc_rise) begin
      if (state_reg.osc_cnt == integ_last(state_reg.resol)) begin
        state_next.osc_cnt = 16'h0000;
        sample = state_reg.mode[1] ? infrared_data_i : ambient_data_i;
        sample = sample & lsci_res_mask(state_reg.resol);
        state_next.result = sample;
        outside = (sample <= state_reg.lower) || (sample >= state_reg.upper);
        if (outside) begin
          pinc = (state_reg.pcnt == 5'h1f) ? state_reg.pcnt : state_reg.pcnt + 5'h01;
          state_next.pcnt = pinc;
          if (pinc >= lsci_persist_n(state_reg.persist)) begin
            state_next.flag = 1'b1;
          end
        end else begin
          state_next.pcnt = 5'h00;
        end
        if (!state_reg.mode[2]) begin
          state_next.fsm = LSCI_HOLD;
        end
      end else begin
        state_next.osc_cnt = state_reg.osc_cnt + 16'h0001;
      end
    end

    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        LSCI_ADDR_MODE: begin
          state_next.persist = reg_req_i.wdata[LSCI_PERSIST_LSB +: 2];
          if (reg_req_i.wdata[LSCI_PERSIST_LSB +: 2] != state_reg.persist) begin
            state_next.pcnt = 5'h00;
          end
          state_next.mode = reg_req_i.wdata[LSCI_MODE_LSB +: 3];
          if (reg_req_i.wdata[LSCI_MODE_LSB +: 3] != state_reg.mode) begin
            state_next.osc_cnt = 16'h0000;
            state_next.fsm = lsci_mode_valid(reg_req_i.wdata[LSCI_MODE_LSB +: 3])
                             ? LSCI_RUN : LSCI_OFF;
          end
        end
        LSCI_ADDR_RANGE: begin
          state_next.scale = reg_req_i.wdata[LSCI_SCALE_LSB +: 2];
          state_next.resol = reg_req_i.wdata[LSCI_RESOL_LSB +: 2];
          if (reg_req_i.wdata[LSCI_RESOL_LSB +: 2] != state_reg.resol) begin
            state_next.osc_cnt = 16'h0000;
          end
        end
        LSCI_ADDR_LLO: state_next.lower[7:0]  = reg_req_i.wdata;
        LSCI_ADDR_LHI: state_next.lower[15:8] = reg_req_i.wdata;
        LSCI_ADDR_ULO: state_next.upper[7:0]  = reg_req_i.wdata;
        LSCI_ADDR_UHI: state_next.upper[15:8] = reg_req_i.wdata;
        default: begin
        end
      endcase
    end

    unique case (reg_req_i.addr)
      LSCI_ADDR_MODE: begin
        state_next.rdata = {state_reg.mode, 2'b00, state_reg.flag, state_reg.persist};
      end
      LSCI_ADDR_RANGE:  state_next.rdata = {4'h0, state_reg.resol, state_reg.scale};
      LSCI_ADDR_RES_LO: state_next.rdata = state_reg.result[7:0];
      LSCI_ADDR_RES_HI: state_next.rdata = state_reg.result[15:8];
      LSCI_ADDR_LLO:    state_next.rdata = state_reg.lower[7:0];
      LSCI_ADDR_LHI:    state_next.rdata = state_reg.lower[15:8];
      LSCI_ADDR_ULO:    state_next.rdata = state_reg.upper[7:0];
      LSCI_ADDR_UHI:    state_next.rdata = state_reg.upper[15:8];
      default:          state_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= LSCI_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o   = state_reg.rdata;
  assign integrating_o = (state_reg.fsm == LSCI_RUN);
  assign ir_sel_o      = state_reg.mode[1];
  assign scale_sel_o   = state_reg.scale;
  assign int_n_o       = ~state_reg.flag;

endmodule
`default_nettype wire
